// File: src/pfc_pkg.sv
// Constants, register map and field layout of the PLL fraction and phase control block.
package pfc_pkg;
	// Wishbone widths.
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int WB_SW = 4;

	// Register byte offsets.
	localparam logic [WB_AW-1:0] OFS_CFG   = 8'h00;
	localparam logic [WB_AW-1:0] OFS_FRAC  = 8'h04;
	localparam logic [WB_AW-1:0] OFS_STAT  = 8'h08;
	localparam logic [WB_AW-1:0] OFS_EFF   = 8'h0C;
	localparam logic [WB_AW-1:0] OFS_RATIO = 8'h10;

	// Configuration word field positions.
	localparam int F_SDO_LSB  = 29;
	localparam int F_SDO_W    = 3;
	localparam int F_IORD_LSB = 21;
	localparam int F_IORD_W   = 2;
	localparam int F_TRIM_LSB = 16;
	localparam int F_TRIM_W   = 5;
	localparam int F_FWD      = 15;
	localparam int F_FBCLR    = 14;
	localparam int F_DRVRST   = 13;
	localparam int F_FSYNC    = 12;
	localparam int F_BACK     = 11;
	localparam int F_RATIO    = 10;
	localparam int F_DENH_W   = 10;
	localparam int F_DENL_W   = 6;

	// Status word field positions.
	localparam int S_PHASE_LSB = 0;
	localparam int S_RATIO     = 3;
	localparam int S_MOD       = 4;
	localparam int S_INACC     = 5;
	localparam int S_BUSY      = 6;

	// Widths of the datapath.
	localparam int FRAC_W  = 28;
	localparam int NUM_LSB = 9;
	localparam int NUM_W   = 16;
	localparam int DEN_W   = 16;
	localparam int PHASE_W = 3;
	localparam int NA_W    = 17;

	// Reset values.
	localparam logic [WB_DW-1:0]  CFG_RESET  = 32'h0000_0000;
	localparam logic [FRAC_W-1:0] FRAC_RESET = 28'h000_0000;

	// Interpolation order codes.
	localparam logic [F_IORD_W-1:0] IORD_EIGHT = 2'h0;
	localparam logic [F_IORD_W-1:0] IORD_FOUR  = 2'h1;
	localparam logic [F_IORD_W-1:0] IORD_TWO   = 2'h2;
	localparam logic [F_IORD_W-1:0] IORD_NONE  = 2'h3;

	// Charge pump step, 3.125 uA expressed in nanoamps.
	localparam logic [NA_W-1:0] PUMP_STEP_NA = 17'h0_0C35;

	// Length of the driver reset part of a forced sync cycle.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SYNC_HOLD_NS  = 20;
	localparam int SYNC_HOLD_CYC = (SYNC_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_CNT_W    = 4;

	// Forced sync sequencer states.
	typedef enum logic [0:0] {
		PFC_SYNC_IDLE,
		PFC_SYNC_HOLD
	} pfc_sync_e;
endpackage

// File: src/pfc_pll_fraction_phase_control.sv
// Register file and control logic for one PLL's fraction, phase step and sync fields.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Decode interpolation order into eight, four, two, none.
// RULE_02 - Reduced order drops low fraction bits. Here only orders two and none drop bits; order four keeps the whole fraction.
// RULE_03 - Pump current is 3.125 uA times code+1.
// RULE_04 - Forward edge advances output one eighth cycle.
// RULE_05 - Phase step ignores interpolation order.
// RULE_06 - Step only on rising edge; host re-arms.
// RULE_07 - Back edge retards output one eighth cycle.
// RULE_08 - Host pulses divider clear after order change.
// RULE_09 - Driver reset bit resets both output drivers.
// RULE_10 - Forced sync runs reset cycle, pulses outputs.
// RULE_11 - Ratio mode: numerator bits 24:9, modulus denominator.
// RULE_12 - Zero denominator means plain fixed-point fraction.
// RULE_13 - Zero modulation order flags too-fine fraction bits.
// RULE_14 - Edges found against previous registered bit.
module pfc_pll_fraction_phase_control (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [pfc_pkg::WB_AW-1:0]   wb_adr_i,
	input  wire logic [pfc_pkg::WB_SW-1:0]   wb_sel_i,
	input  wire logic [pfc_pkg::WB_DW-1:0]   wb_dat_i,
	output logic      [pfc_pkg::WB_DW-1:0]   wb_dat_o,
	output logic                             wb_ack_o,
	output logic      [pfc_pkg::PHASE_W-1:0] phase_sel,
	output logic                             phase_fwd_pulse,
	output logic                             phase_back_pulse,
	output logic      [pfc_pkg::NA_W-1:0]    pump_current_na,
	output logic      [pfc_pkg::FRAC_W-1:0]  frac_effective,
	output logic                             ratio_active,
	output logic      [pfc_pkg::NUM_W-1:0]   ratio_numerator,
	output logic      [pfc_pkg::DEN_W-1:0]   ratio_denominator,
	output logic                             modulation_on,
	output logic                             frac_inaccurate,
	output logic                             fb_div_reset,
	output logic                             first_output_reset,
	output logic                             second_output_reset,
	output logic                             sync_pll_a,
	output logic                             sync_pll_b
);
	import pfc_pkg::*;

	// Cycles from a forced sync edge to the sync pulse at the outputs.
	localparam int SYNC_LAT = SYNC_HOLD_CYC + 1;

	logic [WB_DW-1:0]      cfg;         // Writable configuration word.
	logic [FRAC_W-1:0]     frac;        // Fractional feedback divider word.
	logic                  fwd_prev;    // Forward bit as seen one cycle earlier.
	logic                  back_prev;   // Back bit as seen one cycle earlier.
	logic                  fsync_prev;  // Forced sync bit as seen one cycle earlier.
	logic                  step_fwd;    // Forward edge this cycle.
	logic                  step_back;   // Back edge this cycle.
	logic                  sync_start;  // Forced sync edge this cycle.
	pfc_sync_e             sync_state;  // Forced sync sequencer.
	logic [SYNC_CNT_W-1:0] sync_cnt;    // Cycles spent in the hold part.
	logic                  wb_req;      // A new bus request waits for its answer.
	logic [F_IORD_W-1:0]   iord;        // Interpolation order field.
	logic [F_TRIM_W-1:0]   trim;        // Pump current trim code.
	logic [DEN_W-1:0]      den_raw;     // Modulus assembled from both words.
	logic [WB_DW-1:0]      stat_word;   // Status as read by software.

	// Mask of the low fraction bits that the chosen order cannot use.
	function automatic logic [FRAC_W-1:0] drop_mask(input logic [F_IORD_W-1:0] ord);
		unique case (ord)
			IORD_EIGHT: drop_mask = 28'h000_0000;
			IORD_FOUR:  drop_mask = 28'h000_0000;
			IORD_TWO:   drop_mask = 28'h000_0001;
			IORD_NONE:  drop_mask = 28'h000_0003;
		endcase
	endfunction

	// Fraction bits finer than the phase resolution of the chosen order.
	function automatic logic [FRAC_W-1:0] fine_mask(input logic [F_IORD_W-1:0] ord);
		unique case (ord)
			IORD_EIGHT: fine_mask = 28'h1FF_FFFF;
			IORD_FOUR:  fine_mask = 28'h3FF_FFFF;
			IORD_TWO:   fine_mask = 28'h7FF_FFFF;
			IORD_NONE:  fine_mask = 28'hFFF_FFFF;
		endcase
	endfunction

	// Merges write data into a register under the byte enables.
	function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] old_v,
		input logic [WB_DW-1:0] new_v, input logic [WB_SW-1:0] sel);
		logic [WB_DW-1:0] r;
		r = old_v;
		for (int i = 0; i < WB_SW; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	assign iord    = cfg[F_IORD_LSB +: F_IORD_W];
	assign trim    = cfg[F_TRIM_LSB +: F_TRIM_W];
	// The low six modulus bits share storage with the low fraction bits.
	assign den_raw = {cfg[F_DENH_W-1:0], frac[F_DENL_W-1:0]}; // RULE_11

	// Edge detection compares each bit with its registered copy, so a held bit
	// produces one step only and the host must clear it to re-arm.
	assign step_fwd   = cfg[F_FWD] & ~fwd_prev;     // RULE_14
	assign step_back  = cfg[F_BACK] & ~back_prev;   // RULE_06
	assign sync_start = cfg[F_FSYNC] & ~fsync_prev;

	// A request is answered once; the held request must not be answered twice.
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Status word assembled from live block state.
	always_comb begin
		stat_word = '0;
		stat_word[S_PHASE_LSB +: PHASE_W] = phase_sel;
		stat_word[S_RATIO] = ratio_active;
		stat_word[S_MOD]   = modulation_on;
		stat_word[S_INACC] = frac_inaccurate;
		stat_word[S_BUSY]  = (sync_state == PFC_SYNC_HOLD);
	end

	// Bus answer: one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					OFS_CFG:   wb_dat_o <= cfg;
					OFS_FRAC:  wb_dat_o <= {{(WB_DW-FRAC_W){1'b0}}, frac};
					OFS_STAT:  wb_dat_o <= stat_word;
					OFS_EFF:   wb_dat_o <= {{(WB_DW-FRAC_W){1'b0}}, frac_effective};
					OFS_RATIO: wb_dat_o <= {ratio_denominator, ratio_numerator};
					// Unmapped addresses read as zero.
					default:   wb_dat_o <= '0;
				endcase
			end
		end
	end

	// Writable registers. A write lands at the edge at which the master samples
	// ack high, so a master that drops its request early leaves no trace.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg  <= CFG_RESET;
			frac <= FRAC_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
			if (wb_adr_i == OFS_CFG) begin
				cfg <= merge(cfg, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_FRAC) begin
				frac <= FRAC_W'(merge({{(WB_DW-FRAC_W){1'b0}}, frac}, wb_dat_i, wb_sel_i));
			end
		end
	end

	// Previous copies of the edge-triggered control bits.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fwd_prev   <= 1'b0;
			back_prev  <= 1'b0;
			fsync_prev <= 1'b0;
		end else begin
			fwd_prev   <= cfg[F_FWD];   // RULE_14
			back_prev  <= cfg[F_BACK];  // RULE_14
			fsync_prev <= cfg[F_FSYNC];
		end
	end

	// Eighth-cycle phase selector. The interpolation order is not looked at,
	// so a step is the same size in every mode. Simultaneous edges cancel.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			phase_sel        <= '0;
			phase_fwd_pulse  <= 1'b0;
			phase_back_pulse <= 1'b0;
		end else begin
			phase_fwd_pulse  <= step_fwd;
			phase_back_pulse <= step_back;
			if (step_fwd && !step_back) begin
				phase_sel <= phase_sel + 3'h1; // RULE_04 RULE_05
			end else if (step_back && !step_fwd) begin
				phase_sel <= phase_sel - 3'h1; // RULE_07
			end
		end
	end

	// Pump current and fraction interpretation, registered for clean outputs.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pump_current_na   <= PUMP_STEP_NA;
			frac_effective    <= '0;
			ratio_active      <= 1'b0;
			ratio_numerator   <= '0;
			ratio_denominator <= '0;
			modulation_on     <= 1'b0;
			frac_inaccurate   <= 1'b0;
		end else begin
			pump_current_na <= NA_W'(PUMP_STEP_NA * ({12'h000, trim} + 17'h0_0001)); // RULE_03
			frac_effective  <= frac & ~drop_mask(iord); // RULE_01 RULE_02
			// A zero modulus keeps the plain fixed-point reading.
			ratio_active      <= cfg[F_RATIO] && (den_raw != '0); // RULE_12
			ratio_numerator   <= frac[NUM_LSB +: NUM_W];          // RULE_11
			ratio_denominator <= den_raw;                         // RULE_11
			modulation_on     <= (cfg[F_SDO_LSB +: F_SDO_W] != '0);
			// Without modulation only the phase resolution is exact.
			frac_inaccurate <= (cfg[F_SDO_LSB +: F_SDO_W] == '0) &&
				((frac & fine_mask(iord)) != '0); // RULE_13
		end
	end

	// Forced sync: hold the drivers in reset, then pulse both PLL syncs once.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync_state <= PFC_SYNC_IDLE;
			sync_cnt   <= '0;
			sync_pll_a <= 1'b0;
			sync_pll_b <= 1'b0;
		end else begin
			sync_pll_a <= 1'b0;
			sync_pll_b <= 1'b0;
			unique case (sync_state)
				// An edge that arrives while busy is lost; the host re-arms by clearing.
				PFC_SYNC_IDLE: begin
					sync_cnt <= '0;
					if (sync_start) begin
						sync_state <= PFC_SYNC_HOLD; // RULE_10
					end
				end
				PFC_SYNC_HOLD: begin
					sync_cnt <= sync_cnt + 4'h1;
					if (sync_cnt == SYNC_CNT_W'(SYNC_HOLD_CYC - 1)) begin
						sync_state <= PFC_SYNC_IDLE;
						sync_pll_a <= 1'b1; // RULE_10
						sync_pll_b <= 1'b1; // RULE_10
					end
				end
			endcase
		end
	end

	// Level controls. The divider clear follows the bit; sequencing it after an
	// order or divider change is left to the host.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fb_div_reset        <= 1'b0;
			first_output_reset  <= 1'b0;
			second_output_reset <= 1'b0;
		end else begin
			fb_div_reset        <= cfg[F_FBCLR]; // RULE_08
			first_output_reset  <= cfg[F_DRVRST] || (sync_state == PFC_SYNC_HOLD); // RULE_09
			second_output_reset <= cfg[F_DRVRST] || (sync_state == PFC_SYNC_HOLD); // RULE_09
		end
	end

	// All checks run on the one clock and rest while reset is held.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_fwd_step_once: assert property (step_fwd && !step_back |=> // RULE_04
		phase_sel == $past(phase_sel) + 3'h1) else $error("forward step missed");
	a_back_step_once: assert property (step_back && !step_fwd |=> // RULE_07
		phase_sel == $past(phase_sel) - 3'h1) else $error("back step missed");
	a_edge_single: assert property (step_fwd |=> !step_fwd) // RULE_06
		else $error("forward step repeated");
	a_step_any_order: assert property (!step_fwd && !step_back |=> // RULE_05
		$stable(phase_sel)) else $error("phase moved without a step");
	a_pump_current: assert property (1'b1 |=> // RULE_03
		pump_current_na == NA_W'(PUMP_STEP_NA * (17'($past(trim)) + 17'h0_0001)))
		else $error("pump current wrong");
	a_drop_two: assert property (iord == IORD_TWO |=> frac_effective[0] == 1'b0) // RULE_02
		else $error("last fraction bit kept");
	a_eight_keep: assert property (iord == IORD_EIGHT |=> frac_effective == $past(frac)) // RULE_01
		else $error("eight-phase fraction altered");
	a_zero_den: assert property (den_raw == '0 |=> !ratio_active) // RULE_12
		else $error("ratio with zero modulus");
	a_numer_bits: assert property (1'b1 |=> ratio_numerator == $past(frac[24:9])) // RULE_11
		else $error("numerator bits wrong");
	a_sync_pulse: assert property (sync_start && sync_state == PFC_SYNC_IDLE |-> // RULE_10
		##[SYNC_LAT:SYNC_LAT] sync_pll_a && sync_pll_b) else $error("sync pulse late");
	a_drv_reset: assert property (cfg[F_DRVRST] |=> first_output_reset && second_output_reset) // RULE_09
		else $error("driver reset not applied");
	a_inaccurate: assert property (modulation_on |-> !frac_inaccurate) // RULE_13
		else $error("inaccuracy with modulation on");
	a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	// Order-dependent fraction masking, the back step and the divider clear level.
	a_back_single: assert property (step_back |=> !step_back) // RULE_07
		else $error("back step repeated");
	a_four_keep: assert property (iord == IORD_FOUR |=> frac_effective == $past(frac)) // RULE_01
		else $error("four-phase fraction altered");
	a_drop_none: assert property (iord == IORD_NONE |=> frac_effective[1:0] == 2'h0) // RULE_02
		else $error("low fraction bits kept");
	a_fb_clear: assert property (1'b1 |=> fb_div_reset == $past(cfg[F_FBCLR])) // RULE_08
		else $error("divider clear not followed");

	c_fwd_step: cover property (step_fwd ##1 phase_fwd_pulse);
	c_back_step: cover property (step_back ##1 phase_back_pulse);
	c_sync_done: cover property (sync_pll_a);
	c_ratio_mode: cover property (ratio_active);
	// The driver reset cover shows both output drivers held together.
	c_drv_reset: cover property (first_output_reset && second_output_reset);
endmodule

// File: tb/pfc_host_model.sv
// Host model that writes and reads the configuration registers as a Wishbone master.
`timescale 1ns/1ps
module pfc_host_model (
	input  wire logic                      clk,
	input  wire logic                      ack,
	input  wire logic [pfc_pkg::WB_DW-1:0] rdat,
	output logic                           cyc,
	output logic                           stb,
	output logic                           we,
	output logic      [pfc_pkg::WB_AW-1:0] adr,
	output logic      [pfc_pkg::WB_SW-1:0] sel,
	output logic      [pfc_pkg::WB_DW-1:0] wdat
);
	import pfc_pkg::*;
	// The bus idles from time zero, so no request can land before reset ends.
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0000_0000;
	end
	// One classic cycle; the request is held until ack is sampled high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Set and then clear a control, since steps and forced syncs act on edges only.
	task automatic seq(input logic [7:0] a, input logic [31:0] v1, input logic [31:0] v2);
		logic [31:0] r;
		xfer(1'b1, a, v1, r);
		xfer(1'b1, a, v2, r);
	endtask
endmodule

// File: tb/tb.sv
// Self-checking testbench of the PLL fraction and phase control block.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb;
	import pfc_pkg::*;
	logic        clk;
	logic        reset_n;
	logic        cyc, stb, we, ack, fwd_p, back_p, ratio_on, mod_on, inacc;
	logic        fb_rst, o1_rst, o2_rst, sync_a, sync_b;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, cfg, r;
	logic [27:0] frac, eff;
	logic [2:0]  phase;
	logic [16:0] pump;
	logic [15:0] num, den;
	logic [9:0]  m;
	int          n_errors, comparisons, seed, ph, t, o, i, b, ns, nr;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	pfc_pll_fraction_phase_control i_pfc_pll_fraction_phase_control (
		.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.phase_sel(phase), .phase_fwd_pulse(fwd_p), .phase_back_pulse(back_p),
		.pump_current_na(pump), .frac_effective(eff), .ratio_active(ratio_on),
		.ratio_numerator(num), .ratio_denominator(den), .modulation_on(mod_on),
		.frac_inaccurate(inacc), .fb_div_reset(fb_rst), .first_output_reset(o1_rst),
		.second_output_reset(o2_rst), .sync_pll_a(sync_a), .sync_pll_b(sync_b));
	pfc_host_model i_pfc_host_model (
		.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .wdat(wdat));
	// Fraction with the low bits that the interpolation order ignores cleared.
	function automatic logic [27:0] exp_eff(input logic [27:0] f, input int od);
		exp_eff = (od == 3) ? (f & 28'hFFF_FFFC) : (od == 2) ? (f & 28'hFFF_FFFE) : f;
	endfunction
	// Writes land at the ack edge; registered outputs follow one edge later.
	task automatic wcfg(input logic [31:0] v);
		cfg = v;
		i_pfc_host_model.xfer(1'b1, OFS_CFG, v, r);
		@(posedge clk);
		#1;
	endtask
	task automatic wfrac(input logic [27:0] v);
		frac = v;
		i_pfc_host_model.xfer(1'b1, OFS_FRAC, {4'h0, v}, r);
		@(posedge clk);
		#1;
	endtask
	task automatic final_report;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// A hang is cut short well past the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("unexpected timeout exp 0 got 1");
		final_report;
	end
	initial begin
		seed = 32'h4787;
		n_errors = 0;
		comparisons = 0;
		ph = 0;
		reset_n = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		`CHK("pump", 3125, pump)
		@(posedge clk);
		reset_n <= 1'b1;
		i_pfc_host_model.xfer(1'b0, 8'h3C, 32'h0, r);
		`CHK("unmapped", 0, r)
		$display("test reset done");
		// Trim codes include both ends; every interpolation order is used twice.
		for (i = 0; i < 8; i++) begin
			t = (i == 0) ? 0 : (i == 7) ? 31 : ($random(seed) & 31);
			o = i % 4;
			wfrac($random(seed));
			wcfg(t << 16 | o << 21);
			`CHK("pump", 3125 * (t + 1), pump)
			`CHK("eff", exp_eff(frac, o), eff)
			`CHK("inacc", (frac & ((1 << (25 + o)) - 1)) != 0, inacc)
			`CHK("mod", 0, mod_on)
			i_pfc_host_model.xfer(1'b0, OFS_EFF, 32'h0, r);
			`CHK("eff read", {4'h0, exp_eff(frac, o)}, r)
			// The divider clear is pulsed after each order or divider change.
			i_pfc_host_model.seq(OFS_CFG, cfg | 32'h0000_4000, cfg);
		end
		wcfg(2 << 29);
		`CHK("mod", 1, mod_on)
		`CHK("inacc", 0, inacc)
		$display("test trim and order done");
		// Each step is tried with the bit held too, which must not step again.
		for (i = 0; i < 8; i++) begin
			o = (i % 4) << 21;
			b = (i < 4) ? 15 : 11;
			wcfg(o | 1 << b);
			ph = (ph + ((i < 4) ? 1 : 7)) % 8;
			`CHK("phase", ph, phase)
			`CHK("pulse", 1, (i < 4) ? fwd_p : back_p)
			wcfg(o | 1 << b);
			`CHK("held", ph, phase)
			`CHK("no pulse", 0, fwd_p | back_p)
			wcfg(o);
		end
		i_pfc_host_model.xfer(1'b0, OFS_STAT, 32'h0, r);
		`CHK("stat phase", ph, r[2:0])
		$display("test phase steps done");
		m = $random(seed) | 10'h001;
		wfrac($random(seed));
		i_pfc_host_model.xfer(1'b0, OFS_FRAC, 32'h0, r);
		`CHK("frac read", {4'h0, frac}, r)
		wcfg(1 << 10 | m);
		i_pfc_host_model.xfer(1'b0, OFS_CFG, 32'h0, r);
		`CHK("cfg read", cfg, r)
		`CHK("ratio", 1, ratio_on)
		`CHK("num", frac[24:9], num)
		`CHK("den", {m, frac[5:0]}, den)
		i_pfc_host_model.xfer(1'b0, OFS_RATIO, 32'h0, r);
		`CHK("ratio read", {m, frac[5:0], frac[24:9]}, r)
		wfrac(frac & 28'hFFF_FFC0);
		wcfg(1 << 10);
		`CHK("ratio zero", 0, ratio_on)
		$display("test ratio done");
		wcfg(1 << 13);
		`CHK("out rst", 2'b11, {o1_rst, o2_rst})
		wcfg(1 << 14);
		`CHK("out rst off", 2'b00, {o1_rst, o2_rst})
		`CHK("fb rst", 1, fb_rst)
		wcfg(0);
		`CHK("fb rst off", 0, fb_rst)
		i_pfc_host_model.seq(OFS_CFG, 1 << 12, 0);
		ns = 0;
		nr = 0;
		for (i = 0; i < 10; i++) begin
			@(posedge clk);
			#1;
			ns += (sync_a === 1'b1 && sync_b === 1'b1);
			nr += (o1_rst === 1'b1 && o2_rst === 1'b1);
		end
		`CHK("sync pulses", 1, ns)
		`CHK("sync reset", 1, nr > 0)
		$display("test resets and sync done");
		final_report;
	end
endmodule
